// *** arf_pkg.sv ***
// Package for the asynchronous request filter: offsets, field positions, codes
package arf_pkg;
    localparam logic [11:0] ADMIT_HI_SET_OFS  = 12'h000;
    localparam logic [11:0] ADMIT_HI_CLR_OFS  = 12'h004;
    localparam logic [11:0] ADMIT_LO_SET_OFS  = 12'h008;
    localparam logic [11:0] ADMIT_LO_CLR_OFS  = 12'h00c;
    localparam logic [11:0] PHYS_HI_SET_OFS   = 12'h010;
    localparam logic [11:0] PHYS_HI_CLR_OFS   = 12'h014;
    localparam logic [11:0] PHYS_LO_SET_OFS   = 12'h018;
    localparam logic [11:0] PHYS_LO_CLR_OFS   = 12'h01c;
    localparam logic [11:0] CTRL_OFS          = 12'h020;
    localparam logic [11:0] STATUS_OFS        = 12'h024;
    localparam logic [63:0] FILTER_RESET      = 64'h0;
    localparam logic [9:0]  LOCAL_BUS_CODE    = 10'h3ff;
    localparam int          REMOTE_BIT_POS    = 63;
    localparam logic [47:0] LOW_REGION_TOP    = 48'h0000_ffff_ffff;
    localparam logic [47:0] ROM_FIRST_1K_END  = 48'hffff_f000_07ff;
    localparam logic [47:0] ROM_BASE          = 48'hffff_f000_0400;
    localparam logic [47:0] IRM_BASE          = 48'hffff_f000_021c;
    localparam logic [47:0] IRM_END           = 48'hffff_f000_0228;
    localparam logic [9:0]  CTRL_RESET        = 10'h3ff;
    typedef enum logic [1:0] {
        ARF_DEST_DROP = 2'b00,
        ARF_DEST_DMA  = 2'b01,
        ARF_DEST_PHYS = 2'b10
    } arf_dest_t;
endpackage

// *** arf_match.sv ***
// Node-indexed filter lookup shared by the admission and physical paths
`timescale 1ns/100ps
module arf_match (
    input  wire logic [63:0] filter_i,
    input  wire logic [15:0] source_id_i,
    input  wire logic [9:0]  bus_id_i,
    output logic             hit_o
);
    logic [9:0] src_bus;
    logic [5:0] src_node;
    logic       local_src;
    assign src_bus   = source_id_i[15:6];
    assign src_node  = source_id_i[5:0];
    assign local_src = (src_bus == arf_pkg::LOCAL_BUS_CODE) || (src_bus == bus_id_i);
    always_comb begin
        if (local_src) begin
            // Node 63 is broadcast and never admitted per node
            hit_o = (src_node != 6'h3f) && filter_i[src_node];
        end else begin
            hit_o = filter_i[arf_pkg::REMOTE_BIT_POS];
        end
    end
endmodule // arf_match

// *** arf_filter.sv ***
// Asynchronous request admission and routing filter with APB register slave
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
module arf_filter (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        bus_reset_i,
    input  wire logic        req_valid_i,
    input  wire logic        req_is_response_i,
    input  wire logic        req_quadlet_read_i,
    input  wire logic [15:0] req_source_id_i,
    input  wire logic [47:0] req_offset_i,
    input  wire logic        dma_ctx_enabled_i,
    output logic             dec_valid_o,
    output logic             dec_ack_o,
    output logic             dec_to_dma_o,
    output logic             dec_to_phys_o,
    output logic             local_bus_identifier_o
);
    logic [63:0] admission_filter_reg;
    logic [63:0] physical_route_filter_reg;
    logic [9:0]  local_bus_identifier_reg;
    logic [31:0] dropped_count_reg;
    logic [31:0] prdata_next;
    logic        pslverr_next;
    logic        wr_en;
    logic        access;
    logic        admit_hit;
    logic        phys_hit;
    logic        bypass;
    logic        rom_1k;
    arf_pkg::arf_dest_t dest_next;

    assign access = psel_i && penable_i;
    // Write lands only at the edge that completes the access, never twice
    assign wr_en  = access && pwrite_i && pready_o;

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = (a <= arf_pkg::STATUS_OFS) && (a[1:0] == 2'b00);
    endfunction

    // Set ORs the data in, clear masks it out: one function for both filters
    function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] d,
                                            input logic is_set);
        set_clr = is_set ? (cur | d) : (cur & ~d);
    endfunction

    arf_match u_admit (
        .filter_i    (admission_filter_reg),
        .source_id_i (req_source_id_i),
        .bus_id_i    (local_bus_identifier_reg),
        .hit_o       (admit_hit)
    );
    arf_match u_phys (
        .filter_i    (physical_route_filter_reg),
        .source_id_i (req_source_id_i),
        .bus_id_i    (local_bus_identifier_reg),
        .hit_o       (phys_hit)
    );

    // Admission filter; bus reset outranks a same-cycle write
    always_ff @(posedge core_clk_i) begin
        if (rst_i || bus_reset_i) begin
            admission_filter_reg <= arf_pkg::FILTER_RESET;
        end else if (wr_en) begin
            case (paddr_i)
                arf_pkg::ADMIT_HI_SET_OFS: admission_filter_reg[63:32] <=
                    set_clr(admission_filter_reg[63:32], pwdata_i, 1'b1);
                arf_pkg::ADMIT_HI_CLR_OFS: admission_filter_reg[63:32] <=
                    set_clr(admission_filter_reg[63:32], pwdata_i, 1'b0);
                arf_pkg::ADMIT_LO_SET_OFS: admission_filter_reg[31:0] <=
                    set_clr(admission_filter_reg[31:0], pwdata_i, 1'b1);
                arf_pkg::ADMIT_LO_CLR_OFS: admission_filter_reg[31:0] <=
                    set_clr(admission_filter_reg[31:0], pwdata_i, 1'b0);
                default: admission_filter_reg <= admission_filter_reg;
            endcase
        end
    end

    // Physical filter
    always_ff @(posedge core_clk_i) begin
        if (rst_i || bus_reset_i) begin
            physical_route_filter_reg <= arf_pkg::FILTER_RESET;
        end else if (wr_en) begin
            case (paddr_i)
                arf_pkg::PHYS_HI_SET_OFS: physical_route_filter_reg[63:32] <=
                    set_clr(physical_route_filter_reg[63:32], pwdata_i, 1'b1);
                arf_pkg::PHYS_HI_CLR_OFS: physical_route_filter_reg[63:32] <=
                    set_clr(physical_route_filter_reg[63:32], pwdata_i, 1'b0);
                arf_pkg::PHYS_LO_SET_OFS: physical_route_filter_reg[31:0] <=
                    set_clr(physical_route_filter_reg[31:0], pwdata_i, 1'b1);
                arf_pkg::PHYS_LO_CLR_OFS: physical_route_filter_reg[31:0] <=
                    set_clr(physical_route_filter_reg[31:0], pwdata_i, 1'b0);
                default: physical_route_filter_reg <= physical_route_filter_reg;
            endcase
        end
    end

    // Bus identifier survives bus reset; software reloads it after self-ID
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            local_bus_identifier_reg <= arf_pkg::CTRL_RESET;
        end else if (wr_en && paddr_i == arf_pkg::CTRL_OFS) begin
            local_bus_identifier_reg <= pwdata_i[9:0];
        end
    end

    // Read mux
    always_comb begin
        prdata_next  = 32'h0;
        pslverr_next = !known_addr(paddr_i);
        case (paddr_i)
            arf_pkg::ADMIT_HI_SET_OFS,
            arf_pkg::ADMIT_HI_CLR_OFS: prdata_next = admission_filter_reg[63:32];
            arf_pkg::ADMIT_LO_SET_OFS,
            arf_pkg::ADMIT_LO_CLR_OFS: prdata_next = admission_filter_reg[31:0];
            arf_pkg::PHYS_HI_SET_OFS,
            arf_pkg::PHYS_HI_CLR_OFS: prdata_next = physical_route_filter_reg[63:32];
            arf_pkg::PHYS_LO_SET_OFS,
            arf_pkg::PHYS_LO_CLR_OFS: prdata_next = physical_route_filter_reg[31:0];
            arf_pkg::CTRL_OFS:   prdata_next = {22'h0, local_bus_identifier_reg};
            arf_pkg::STATUS_OFS: prdata_next = dropped_count_reg;
            default:             prdata_next = 32'h0;
        endcase
    end

    // APB answer: pready rises one cycle into the access phase
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && penable_i && !pready_o;
            prdata_o  <= (access && !pready_o && !pwrite_i) ? prdata_next : 32'h0;
            pslverr_o <= access && !pready_o && pslverr_next;
        end
    end

    // Request classification
    assign rom_1k = (req_offset_i >= arf_pkg::ROM_BASE) &&
                    (req_offset_i <= arf_pkg::ROM_FIRST_1K_END);
    assign bypass = (req_quadlet_read_i && rom_1k) ||
                    ((req_offset_i >= arf_pkg::IRM_BASE) && (req_offset_i < arf_pkg::IRM_END));

    always_comb begin
        dest_next = arf_pkg::ARF_DEST_DROP;
        if (bypass || rom_1k) begin
            dest_next = arf_pkg::ARF_DEST_PHYS;
        end else if (!admit_hit) begin
            dest_next = arf_pkg::ARF_DEST_DROP;
        end else if (req_offset_i > arf_pkg::LOW_REGION_TOP) begin
            dest_next = dma_ctx_enabled_i ? arf_pkg::ARF_DEST_DMA : arf_pkg::ARF_DEST_DROP;
        end else if (phys_hit) begin
            dest_next = arf_pkg::ARF_DEST_PHYS;
        end else begin
            dest_next = dma_ctx_enabled_i ? arf_pkg::ARF_DEST_DMA : arf_pkg::ARF_DEST_DROP;
        end
    end

    // Decision, one cycle after request; responses pass unfiltered to no unit here
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dec_valid_o   <= 1'b0;
            dec_ack_o     <= 1'b0;
            dec_to_dma_o  <= 1'b0;
            dec_to_phys_o <= 1'b0;
        end else begin
            dec_valid_o   <= req_valid_i && !req_is_response_i;
            dec_ack_o     <= req_valid_i && !req_is_response_i &&
                             (dest_next != arf_pkg::ARF_DEST_DROP);
            dec_to_dma_o  <= req_valid_i && !req_is_response_i &&
                             (dest_next == arf_pkg::ARF_DEST_DMA);
            dec_to_phys_o <= req_valid_i && !req_is_response_i &&
                             (dest_next == arf_pkg::ARF_DEST_PHYS);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dropped_count_reg <= 32'h0;
        end else if (req_valid_i && !req_is_response_i && dest_next == arf_pkg::ARF_DEST_DROP) begin
            dropped_count_reg <= dropped_count_reg + 32'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            local_bus_identifier_o <= 1'b0;
        end else begin
            local_bus_identifier_o <= (local_bus_identifier_reg != arf_pkg::LOCAL_BUS_CODE);
        end
    end
endmodule // arf_filter

// *** arf_filter_monitor.sv ***
// Checker of request decisions and register handshake of the filter
`timescale 1ns/100ps
module arf_filter_monitor (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        bus_reset_i,
    input wire logic        req_valid_i,
    input wire logic        req_is_response_i,
    input wire logic [47:0] req_offset_i,
    input wire logic        dma_ctx_enabled_i,
    input wire logic        dec_valid_o,
    input wire logic        dec_ack_o,
    input wire logic        dec_to_dma_o,
    input wire logic        dec_to_phys_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic req_q;
    assign req_q = req_valid_i && !req_is_response_i;
    property p_resp; req_valid_i && req_is_response_i |=> !dec_valid_o; endproperty
    a_resp: assert property (p_resp) else $error("response was filtered");
    property p_dec; req_q |=> dec_valid_o; endproperty
    a_dec: assert property (p_dec) else $error("request got no decision");
    property p_drop; dec_valid_o && !dec_ack_o |-> !dec_to_dma_o && !dec_to_phys_o; endproperty
    a_drop: assert property (p_drop) else $error("dropped request was routed");
    property p_route; dec_ack_o |-> dec_to_dma_o ^ dec_to_phys_o; endproperty
    a_route: assert property (p_route) else $error("accepted request not routed once");
    property p_high;
        req_q && req_offset_i[47:32] != 16'h0 && req_offset_i[47:32] != 16'hffff
            |=> !dec_to_phys_o;
    endproperty
    a_high: assert property (p_high) else $error("high offset sent to physical unit");
    property p_dmaoff; req_valid_i && !dma_ctx_enabled_i |=> !dec_to_dma_o; endproperty
    a_dmaoff: assert property (p_dmaoff) else $error("disabled context got request");
    property p_clr; bus_reset_i ##1 (req_q && req_offset_i[47:32] == 16'h0) |=> !dec_ack_o;
    endproperty
    a_clr: assert property (p_clr) else $error("request admitted after bus reset");
    property p_ready; psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o; endproperty
    a_ready: assert property (p_ready) else $error("register access not answered");
    property p_idle; !pready_o |-> prdata_o == 32'h0 && !pslverr_o; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    c_drop: cover property (dec_valid_o && !dec_ack_o);
    c_dma: cover property (dec_to_dma_o);
    c_phys: cover property (dec_to_phys_o);
endmodule // arf_filter_monitor

bind arf_filter arf_filter_monitor mon_u (.*);

// *** arf_link_model.sv ***
// Link-side model that presents received requests one cycle each
`timescale 1ns/100ps
module arf_link_model (
    input  wire logic        clk_i,
    output logic             valid_o,
    output logic             resp_o,
    output logic             qread_o,
    output logic [15:0]      src_o,
    output logic [47:0]      ofs_o
);
    initial begin
        valid_o = 1'b0;
        {resp_o, qread_o, src_o, ofs_o} = '0;
    end
    task automatic send(input logic r, input logic q, input logic [15:0] s,
                        input logic [47:0] o);
        @(posedge clk_i);
        valid_o <= 1'b1;
        {resp_o, qread_o, src_o, ofs_o} <= {r, q, s, o};
        @(posedge clk_i);
        valid_o <= 1'b0;
        // Scrambled so a stale field is never mistaken for a live one
        {resp_o, qread_o, src_o, ofs_o} <= ~{r, q, s, o};
    endtask
endmodule // arf_link_model

// *** arf_filter_tb.sv ***
// Random and corner tests of the request filter
`timescale 1ns/100ps
module arf_filter_tb;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, brst = 0, dma = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, prd, rd, v, sh [4];
    logic        rdy, err, e, dv, ack, tdma, tphy, vld, rsp, qr, lbi;
    logic [15:0] src, s;
    logic [47:0] ofs, o;
    logic [9:0]  bid;
    logic [2:0]  x;
    integer      failures = 0, checks_done = 0, seed = 32'hac13, cyc = 0, i, r, drops = 0;
    always #12.5 clk = ~clk;
    arf_link_model lnk_u (.clk_i(clk), .valid_o(vld), .resp_o(rsp), .qread_o(qr),
                          .src_o(src), .ofs_o(ofs));
    arf_filter dut_u (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
        .pslverr_o(err), .bus_reset_i(brst), .req_valid_i(vld), .req_is_response_i(rsp),
        .req_quadlet_read_i(qr), .req_source_id_i(src), .req_offset_i(ofs),
        .dma_ctx_enabled_i(dma), .dec_valid_o(dv), .dec_ack_o(ack), .dec_to_dma_o(tdma),
        .dec_to_phys_o(tphy), .local_bus_identifier_o(lbi));
    task automatic chk(input string n, input logic [31:0] xp, input logic [31:0] g);
        checks_done++;
        if (g !== xp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, xp, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        // The wait ends once rdy is seen high; only the bench timeout ends it if rdy never rises
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rd = prd;
        e = err;
        {psel, pen} <= 2'b00;
    endtask
    function automatic logic hit(input logic [63:0] f, input logic [15:0] sid);
        if (sid[15:6] == 10'h3ff || sid[15:6] == bid)
            return sid[5:0] != 6'd63 && f[sid[5:0]];
        return f[63];
    endfunction
    function automatic logic [2:0] expd(input logic [15:0] sid, input logic [47:0] a,
                                        input logic en);
        if ((a >= arf_pkg::ROM_BASE && a <= arf_pkg::ROM_FIRST_1K_END) ||
            (a >= arf_pkg::IRM_BASE && a < arf_pkg::IRM_END))
            return 3'b101;
        if (!hit({sh[0], sh[1]}, sid))
            return 3'b000;
        if (a <= arf_pkg::LOW_REGION_TOP && hit({sh[2], sh[3]}, sid))
            return 3'b101;
        return en ? 3'b110 : 3'b000;
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i <= 44; i += 4) begin
            apb(0, 12'(i), 0);
            chk("reset value", i == 32 ? 32'h3ff : 32'h0, rd);
            chk("error flag", {31'h0, i > 36}, {31'h0, e});
        end
        $display("test reset values done");
        sh = '{default: 32'h0};
        for (i = 0; i < 24; i++) begin
            r = $random(seed) & 3;
            v = $random(seed);
            apb(1, 12'(r * 8 + (i & 4)), v);
            sh[r] = (i & 4) ? sh[r] & ~v : sh[r] | v;
            apb(0, 12'(r * 8), 0);
            chk("filter set read", sh[r], rd);
            apb(0, 12'(r * 8 + 4), 0);
            chk("filter clear read", sh[r], rd);
        end
        $display("test set and clear done");
        bid = 10'($random(seed));
        apb(1, arf_pkg::CTRL_OFS, {22'h0, bid});
        for (i = 0; i < 300; i++) begin
            r = $random(seed);
            dma <= r[4];
            s = {r[1:0] == 0 ? 10'h3ff : r[1] ? bid : 10'(r >> 16), 6'(r >> 10)};
            case (r[3:2])
                0: o = {16'h0, 32'($random(seed))};
                1: o = {16'h1 + 16'(r[30:16]), 32'($random(seed))};
                2: o = arf_pkg::ROM_BASE + 48'(r[25:16]);
                default: o = arf_pkg::IRM_BASE + 48'(r[17:16]) * 4;
            endcase
            lnk_u.send(r[7:5] == 0, r[8], s, o);
            #1;
            x = r[7:5] == 0 ? 3'b000 : expd(s, o, r[4]);
            if (r[7:5] != 0 && !x[2])
                drops++;
            chk("decision valid", {31'h0, r[7:5] != 0}, {31'h0, dv});
            chk("decision", {29'h0, x}, {29'h0, ack, tdma, tphy});
        end
        $display("test routing done");
        // Node 0 admitted and physical, so only the bus reset can drop it
        apb(1, arf_pkg::ADMIT_LO_SET_OFS, 32'h1);
        apb(1, arf_pkg::PHYS_LO_SET_OFS, 32'h1);
        @(posedge clk);
        brst <= 1'b1;
        lnk_u.send(0, 0, 16'hffc0, 48'h0);
        brst <= 1'b0;
        #1;
        chk("ack after bus reset", 32'h0, {31'h0, ack});
        drops++;
        for (i = 0; i < 4; i++) begin
            apb(0, 12'(i * 8), 0);
            chk("filter after bus reset", 32'h0, rd);
        end
        apb(0, arf_pkg::CTRL_OFS, 0);
        chk("bus id kept", {22'h0, bid}, rd);
        chk("bus id flag", {31'h0, bid != 10'h3ff}, {31'h0, lbi});
        apb(0, arf_pkg::STATUS_OFS, 0);
        chk("dropped count", drops, rd);
        $display("test bus reset done");
        end_sim();
    end
endmodule // arf_filter_tb
